// [rcma_core.sv]
/*
 * reference clock monitor and alarms: configuration holding, output dividers,
 * loop feedback dividers, edge watchdogs, lock flag and input switching.
 * assumes clock inputs are level samples and vco_tick a one-cycle pulse per
 * oscillator edge, all synchronous to clk.
 */
`timescale 1ns/1ps
module rcma_core
   import rcma_pkg::*;
(
   input wire logic clk,
   input wire logic resetn,
   input wire logic ce,
   input wire logic cfg_write,
   input wire rcma_cfg_t cfg_in,
   input wire logic clk_sel_pin,
   input wire logic crystal_in,
   input wire logic ref_input_zero,
   input wire logic ref_input_one,
   input wire logic vco_tick,
   output rcma_cfg_t cfg,
   output logic cfg_refused,
   output logic out0_clk,
   output logic out1_clk,
   output logic upper_fb_edge,
   output logic lower_fb_edge,
   output logic pd_ref_edge,
   output logic crystal_fault_alarm,
   output logic input_zero_fault_alarm,
   output logic input_one_fault_alarm,
   output logic pll_locked_flag,
   output logic active_input,
   output logic ref_lost_alarm,
   output rcma_status_t status
);

   // divide ratio legal only inside the supported window
   function automatic logic div_ok(input logic [7:0] n);
      div_ok = (n >= RCMA_DIV_MIN) && (n <= RCMA_DIV_MAX);
   endfunction

   // watchdog: monitored edge clears, feedback edge counts up to the limit
   function automatic logic [1:0] wd_next(input logic [1:0] cnt, input logic fb,
                                          input logic mon);
      if (mon) begin
         wd_next = 2'h0;
      end else if (fb && cnt != RCMA_MISS_LIMIT) begin
         wd_next = cnt + 2'h1;
      end else begin
         wd_next = cnt;
      end
   endfunction

   logic xtal_prev, ref0_prev, ref1_prev;
   logic [7:0] out0_cnt, out1_cnt;
   logic [7:0] pre_cnt;
   logic [16:0] lower_cnt;
   logic [8:0] upper_cnt;
   logic [15:0] frac_acc;
   logic [1:0] xtal_miss, ref0_miss, ref1_miss;
   logic [3:0] lock_cnt;
   logic acquiring;

   // edge detection on sampled levels
   wire xtal_edge = crystal_in & ~xtal_prev;
   wire ref0_edge = ref_input_zero & ~ref0_prev;
   wire ref1_edge = ref_input_one & ~ref1_prev;
   wire act_edge = active_input ? ref1_edge : ref0_edge;
   wire act_level = active_input ? ref_input_one : ref_input_zero;

   // configuration acceptance
   wire div0_bad = !div_ok(cfg_in.out0_divide_ratio); // [R1]
   wire div1_bad = !div_ok(cfg_in.out1_divide_ratio); // [R1]
   wire prediv_bad = (cfg_in.mode == RCMA_MODE_HIGH_BW)
                     && (cfg_in.pre_divider < RCMA_PFD_MIN_PREDIV); // [R17]
   wire mode_bad = (cfg_in.mode != RCMA_MODE_LOW_BW) && (cfg_in.mode != RCMA_MODE_HIGH_BW)
                   && (cfg_in.mode != RCMA_MODE_SYNTH); // [R4]
   wire cfg_bad = div0_bad | div1_bad | prediv_bad | mode_bad
                  | (cfg_in.lower_loop_feedback_divider == 17'h00000)
                  | (cfg_in.upper_int_divider == 8'h00);
   wire is_low = (cfg.mode == RCMA_MODE_LOW_BW);
   wire is_high = (cfg.mode == RCMA_MODE_HIGH_BW);
   wire is_synth = (cfg.mode == RCMA_MODE_SYNTH);

   // feedback dividers: fractional upper loop, integer lower loop
   wire [16:0] frac_sum = {1'b0, frac_acc} + {1'b0, cfg.upper_frac};
   wire frac_carry = is_synth & frac_sum[16]; // [R19]
   wire [8:0] upper_target = {1'b0, cfg.upper_int_divider} + {8'h00, frac_carry}; // [R19]
   wire upper_wrap = vco_tick && (upper_cnt + 9'h001 >= upper_target);
   wire lower_wrap = vco_tick
                     && (lower_cnt + 17'h00001 >= cfg.lower_loop_feedback_divider); // [R18]
   wire pre_wrap = act_edge && (pre_cnt + 8'h01 >= cfg.pre_divider); // [R17]

   // watchdogs: reference ones take feedback by mode
   wire ref_fb = is_high ? upper_wrap : (is_low ? lower_wrap : 1'b0); // [R7]
   wire [1:0] next_xtal_miss = wd_next(xtal_miss, upper_wrap, xtal_edge); // [R5] [R6] [R20]
   wire [1:0] next_ref0_miss = wd_next(ref0_miss, ref_fb, ref0_edge); // [R8] [R20]
   wire [1:0] next_ref1_miss = wd_next(ref1_miss, ref_fb, ref1_edge); // [R9] [R20]
   wire next_xtal_bad = (next_xtal_miss == RCMA_MISS_LIMIT); // [R5] [R6]
   wire next_ref0_bad = (next_ref0_miss == RCMA_MISS_LIMIT); // [R8]
   wire next_ref1_bad = (next_ref1_miss == RCMA_MISS_LIMIT); // [R9]

   // input selection policy
   wire manual = (cfg.switch_policy_field == RCMA_POL_MANUAL_PIN)
                 || (cfg.switch_policy_field == RCMA_POL_MANUAL_REG); // [R15]
   wire manual_sel = (cfg.switch_policy_field == RCMA_POL_MANUAL_PIN)
                     ? clk_sel_pin : cfg.pref_sel; // [R22]
   wire pref = cfg.pref_sel;
   wire pref_bad = pref ? next_ref1_bad : next_ref0_bad;
   wire cur_bad = active_input ? next_ref1_bad : next_ref0_bad;
   wire oth_bad = active_input ? next_ref0_bad : next_ref1_bad;
   logic next_active;
   always_comb begin
      next_active = active_input;
      if (manual) begin
         next_active = manual_sel; // [R15]
      end else if (acquiring) begin
         next_active = pref; // no hunting while locking after reset or reference loss
      end else if (cfg.switch_policy_field == RCMA_POL_REVERTIVE && !pref_bad) begin
         next_active = pref; // [R21]
      end else if (cur_bad && !oth_bad) begin
         next_active = ~active_input; // [R21]
      end
   end

   // reference loss outside synthesis: selected input in manual, both inputs in automatic
   wire next_lost = is_synth ? 1'b0
                  : manual ? (manual_sel ? next_ref1_bad : next_ref0_bad) // [R12]
                  : (next_ref0_bad & next_ref1_bad); // [R13]

   // lock: reference for the mode must be present through a run of comparisons
   wire mode_ref_bad = is_synth ? next_xtal_bad
                     : (next_lost | (is_low & next_xtal_bad)); // [R10]
   wire cmp_edge = is_low ? lower_wrap : upper_wrap;
   wire lock_hit = cmp_edge && (lock_cnt == RCMA_LOCK_EDGES - 4'h1);
   wire next_locked = !mode_ref_bad && (pll_locked_flag || lock_hit); // [R10]

   // output dividers: high for the first half of each period
   wire out0_wrap = vco_tick && (out0_cnt + 8'h01 >= cfg.out0_divide_ratio); // [R2]
   wire out1_wrap = vco_tick && (out1_cnt + 8'h01 >= cfg.out1_divide_ratio); // [R2]
   wire out0_div = (out0_cnt < {1'b0, cfg.out0_divide_ratio[7:1]});
   wire out1_div = (out1_cnt < {1'b0, cfg.out1_divide_ratio[7:1]});
   wire next_out0 = cfg.output_ref_passthrough[0] ? act_level : out0_div; // [R3]
   wire next_out1 = cfg.output_ref_passthrough[1] ? act_level : out1_div; // [R3]

   // configuration register: defaults at reset, legal writes override
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         cfg <= RCMA_CFG_DEFAULT; // [R16]
         cfg_refused <= 1'b0;
      end else if (ce) begin
         cfg_refused <= cfg_write & cfg_bad; // [R1]
         if (cfg_write && !cfg_bad) begin
            cfg <= cfg_in; // [R16] [R4]
         end
      end
   end

   // edge history
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         xtal_prev <= 1'b0;
         ref0_prev <= 1'b0;
         ref1_prev <= 1'b0;
      end else if (ce) begin
         xtal_prev <= crystal_in;
         ref0_prev <= ref_input_zero;
         ref1_prev <= ref_input_one;
      end
   end

   // output divider counters
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         out0_cnt <= 8'h00;
         out1_cnt <= 8'h00;
         out0_clk <= 1'b0;
         out1_clk <= 1'b0;
      end else if (ce) begin
         if (vco_tick) begin
            out0_cnt <= out0_wrap ? 8'h00 : out0_cnt + 8'h01;
            out1_cnt <= out1_wrap ? 8'h00 : out1_cnt + 8'h01;
         end
         out0_clk <= next_out0;
         out1_clk <= next_out1;
      end
   end

   // loop feedback dividers and input pre-divider
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         upper_cnt <= 9'h000;
         lower_cnt <= 17'h00000;
         pre_cnt <= 8'h00;
         frac_acc <= 16'h0000;
         upper_fb_edge <= 1'b0;
         lower_fb_edge <= 1'b0;
         pd_ref_edge <= 1'b0;
      end else if (ce) begin
         if (vco_tick) begin
            upper_cnt <= upper_wrap ? 9'h000 : upper_cnt + 9'h001;
            lower_cnt <= lower_wrap ? 17'h00000 : lower_cnt + 17'h00001;
         end
         if (upper_wrap && is_synth) begin
            frac_acc <= frac_sum[15:0]; // [R19]
         end
         if (act_edge) begin
            pre_cnt <= pre_wrap ? 8'h00 : pre_cnt + 8'h01; // [R17]
         end
         upper_fb_edge <= upper_wrap;
         lower_fb_edge <= lower_wrap; // [R18]
         pd_ref_edge <= is_high ? pre_wrap : (is_low ? pre_wrap : xtal_edge);
      end
   end

   // watchdog counters and alarm pins
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         xtal_miss <= 2'h0;
         ref0_miss <= 2'h0;
         ref1_miss <= 2'h0;
         crystal_fault_alarm <= 1'b0;
         input_zero_fault_alarm <= 1'b0;
         input_one_fault_alarm <= 1'b0;
         ref_lost_alarm <= 1'b0;
      end else if (ce) begin
         xtal_miss <= next_xtal_miss;
         ref0_miss <= next_ref0_miss;
         ref1_miss <= next_ref1_miss;
         crystal_fault_alarm <= next_xtal_bad; // [R5] [R6] [R14]
         input_zero_fault_alarm <= next_ref0_bad; // [R8] [R14]
         input_one_fault_alarm <= next_ref1_bad; // [R9] [R14]
         ref_lost_alarm <= next_lost; // [R12] [R13] [R14]
      end
   end

   // lock tracking and active input
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         lock_cnt <= 4'h0;
         pll_locked_flag <= 1'b0;
         acquiring <= 1'b1;
         active_input <= 1'b0;
      end else if (ce) begin
         if (mode_ref_bad) begin
            lock_cnt <= 4'h0; // [R10]
         end else if (cmp_edge && !lock_hit) begin
            lock_cnt <= lock_cnt + 4'h1;
         end
         pll_locked_flag <= next_locked; // [R10]
         if (next_locked) begin
            acquiring <= 1'b0;
         end else if (next_lost) begin
            acquiring <= 1'b1;
         end
         active_input <= next_active; // [R11]
      end
   end

   // register status bits mirror the alarm pins
   assign status = '{
      crystal_fault_alarm: crystal_fault_alarm,
      input_zero_fault_alarm: input_zero_fault_alarm,
      input_one_fault_alarm: input_one_fault_alarm,
      pll_locked_flag: pll_locked_flag,
      active_input: active_input,
      ref_lost_alarm: ref_lost_alarm
   }; // [R14]

endmodule

// [rcma_core_checker.sv]
/* concurrent checks on the reference clock monitor core ports.
   assumes one clock domain and the package types. */
`timescale 1ns/1ps
module rcma_mon
   import rcma_pkg::*;
(
   input wire logic clk,
   input wire logic resetn,
   input wire logic ce,
   input wire logic cfg_write,
   input wire rcma_cfg_t cfg_in,
   input wire logic clk_sel_pin,
   input wire logic crystal_in,
   input wire logic ref_input_zero,
   input wire logic ref_input_one,
   input wire rcma_cfg_t cfg,
   input wire logic cfg_refused,
   input wire logic upper_fb_edge,
   input wire logic lower_fb_edge,
   input wire logic crystal_fault_alarm,
   input wire logic input_zero_fault_alarm,
   input wire logic input_one_fault_alarm,
   input wire logic pll_locked_flag,
   input wire logic active_input,
   input wire logic ref_lost_alarm,
   input wire rcma_status_t status
);
   logic ok_w;
   logic fb_now;
   logic is_man;
   logic sel_bad;
   // legality of an offered word, feedback source, selected input alarm
   assign ok_w = cfg_in.out0_divide_ratio >= RCMA_DIV_MIN
      && cfg_in.out0_divide_ratio <= RCMA_DIV_MAX && cfg_in.out1_divide_ratio >= RCMA_DIV_MIN
      && cfg_in.out1_divide_ratio <= RCMA_DIV_MAX && cfg_in.mode != 2'h3
      && cfg_in.lower_loop_feedback_divider != 17'h0 && cfg_in.upper_int_divider != 8'h0
      && !(cfg_in.mode == RCMA_MODE_HIGH_BW && cfg_in.pre_divider < RCMA_PFD_MIN_PREDIV);
   assign fb_now = (cfg.mode == RCMA_MODE_HIGH_BW) ? upper_fb_edge : lower_fb_edge;
   assign is_man = cfg.switch_policy_field inside {RCMA_POL_MANUAL_PIN, RCMA_POL_MANUAL_REG};
   assign sel_bad = ((cfg.switch_policy_field == RCMA_POL_MANUAL_PIN) ? clk_sel_pin
      : cfg.pref_sel) ? input_one_fault_alarm : input_zero_fault_alarm;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);

   AST_STATUS_PINS: assert property (status == {crystal_fault_alarm,
      input_zero_fault_alarm, input_one_fault_alarm, pll_locked_flag, active_input,
      ref_lost_alarm}) else $error("status differs from pins");
   AST_BAD_CFG: assert property (ce && cfg_write && !ok_w |=>
      cfg_refused && $stable(cfg)) else $error("bad word not refused");
   AST_CFG_LOAD: assert property (ce && cfg_write && ok_w |=>
      cfg == $past(cfg_in) && !cfg_refused) else $error("good word not loaded");
   AST_XTAL_CLEAR: assert property (ce && $past(ce) && $rose(crystal_in) |=>
      !crystal_fault_alarm) else $error("crystal alarm kept");
   AST_ZERO_CLEAR: assert property (ce && $past(ce) && $rose(ref_input_zero)
      && cfg.mode != RCMA_MODE_SYNTH |=> !input_zero_fault_alarm) else $error("zero alarm kept");
   AST_ONE_CLEAR: assert property (ce && $past(ce) && $rose(ref_input_one)
      && cfg.mode != RCMA_MODE_SYNTH |=> !input_one_fault_alarm) else $error("one alarm kept");
   AST_XTAL_RISE: assert property ($rose(crystal_fault_alarm) |->
      upper_fb_edge || $past(upper_fb_edge)) else $error("crystal alarm without feedback");
   AST_REF_SRC: assert property ($rose(input_zero_fault_alarm) && $stable(cfg) |->
      fb_now || $past(fb_now)) else $error("zero alarm on wrong feedback");
   AST_LOST_MAN: assert property (is_man && cfg.mode != RCMA_MODE_SYNTH && $stable(cfg)
      && $stable(clk_sel_pin) && $stable(sel_bad) |-> ref_lost_alarm == sel_bad)
      else $error("manual lost alarm wrong");
   AST_LOST_AUTO: assert property (!is_man && cfg.mode != RCMA_MODE_SYNTH && $stable(cfg)
      && $stable({input_zero_fault_alarm, input_one_fault_alarm}) |->
      ref_lost_alarm == (input_zero_fault_alarm && input_one_fault_alarm))
      else $error("auto lost alarm wrong");
   AST_ACTIVE_PIN: assert property ((ce && cfg.switch_policy_field == RCMA_POL_MANUAL_PIN
      && $stable(clk_sel_pin)) [*2] |-> active_input == clk_sel_pin)
      else $error("active input not following pin");
   AST_LOCK_DROP: assert property ($rose(crystal_fault_alarm)
      && cfg.mode != RCMA_MODE_HIGH_BW |-> ##[0:1] !pll_locked_flag) else $error("lock kept");

   // main scenarios reached
   COV_XTAL: cover property ($rose(crystal_fault_alarm));
   COV_LOCK: cover property ($rose(pll_locked_flag));
   COV_REFUSE: cover property (cfg_refused);
endmodule

bind rcma_core rcma_mon u_mon (.clk, .resetn, .ce, .cfg_write, .cfg_in, .clk_sel_pin,
   .crystal_in, .ref_input_zero, .ref_input_one, .cfg, .cfg_refused, .upper_fb_edge,
   .lower_fb_edge, .crystal_fault_alarm, .input_zero_fault_alarm, .input_one_fault_alarm,
   .pll_locked_flag, .active_input, .ref_lost_alarm, .status);

// [rcma_pkg.sv]
/*
 * constants, types and configuration layout for the reference clock monitor,
 * alarm and divider control block.
 * assumes one 100 MHz clock; all pin levels arrive synchronous to it.
 */
// How it works
// [R1] output divide ratios accepted only from 2 to 254; other codes are refused
// [R2] each output has an 8-bit field whose binary value is its divide ratio
// [R3] passthrough bit makes an output copy the active reference instead of divided clock
// [R4] two-bit mode field picks low-bandwidth, high-bandwidth translation or synthesis
// [R5] crystal alarm rises after three upper feedback edges without a crystal edge
// [R6] crystal alarm falls at once on a single crystal edge
// [R7] reference watchdogs use upper feedback in high-bandwidth, lower feedback in low-bandwidth
// [R8] input-zero alarm rises after three feedback edges without its edge, clears on edge
// [R9] input-one alarm behaves the same, watching input one with its own output
// [R10] lock flag rises only after stable lock, drops as soon as lock is lost
// [R11] active-input flag shows which reference drives the output frequency
// [R12] manual switching: reference-lost alarm whenever the selected input is bad; the code holds it low in synthesis mode
// [R13] automatic switching: reference-lost alarm only when both inputs are bad
// [R14] every alarm is shown on a dedicated pin and a status bit
// [R15] switching policies are manual, revertive automatic and non-revertive automatic
// [R16] reset loads factory defaults; writes override them until the next reset
// [R17] high-bandwidth mode pre-divides the input to keep comparison below 100 MHz
// [R18] low-bandwidth lower loop divides oscillator ticks by a 17-bit feedback divider
// [R19] synthesis upper loop divider supports fractional ratios by delta-sigma dither
// [R20] a monitored edge clears its watchdog counter so only consecutive misses count
// [R21] revertive returns to preferred input when valid; non-revertive stays on alternate
// [R22] pin-driven manual mode: select pin low picks input zero, high picks input one
package rcma_pkg;

   typedef enum logic [1:0] {
      RCMA_MODE_LOW_BW,
      RCMA_MODE_HIGH_BW,
      RCMA_MODE_SYNTH
   } rcma_mode_t;

   typedef enum logic [1:0] {
      RCMA_POL_MANUAL_PIN,
      RCMA_POL_MANUAL_REG,
      RCMA_POL_REVERTIVE,
      RCMA_POL_NONREVERTIVE
   } rcma_policy_t;

   typedef struct packed {
      rcma_mode_t mode;
      rcma_policy_t switch_policy_field;
      logic pref_sel;
      logic [7:0] out0_divide_ratio;
      logic [7:0] out1_divide_ratio;
      logic [1:0] output_ref_passthrough;
      logic [7:0] pre_divider;
      logic [16:0] lower_loop_feedback_divider;
      logic [7:0] upper_int_divider;
      logic [15:0] upper_frac;
   } rcma_cfg_t;

   typedef struct packed {
      logic crystal_fault_alarm;
      logic input_zero_fault_alarm;
      logic input_one_fault_alarm;
      logic pll_locked_flag;
      logic active_input;
      logic ref_lost_alarm;
   } rcma_status_t;

   localparam logic [7:0] RCMA_DIV_MIN = 8'h02;
   localparam logic [7:0] RCMA_DIV_MAX = 8'hfe;
   localparam logic [1:0] RCMA_MISS_LIMIT = 2'h3;
   localparam logic [3:0] RCMA_LOCK_EDGES = 4'h8;
   localparam int RCMA_CLK_MHZ = 100;
   localparam int RCMA_PFD_MAX_MHZ = 100;
   localparam logic [7:0] RCMA_PFD_MIN_PREDIV = 8'(1 + (RCMA_CLK_MHZ / RCMA_PFD_MAX_MHZ));

   localparam rcma_cfg_t RCMA_CFG_DEFAULT = '{
      mode: RCMA_MODE_LOW_BW,
      switch_policy_field: RCMA_POL_MANUAL_PIN,
      pref_sel: 1'b0,
      out0_divide_ratio: 8'h04,
      out1_divide_ratio: 8'h04,
      output_ref_passthrough: 2'h0,
      pre_divider: 8'h02,
      lower_loop_feedback_divider: 17'h00010,
      upper_int_divider: 8'h04,
      upper_frac: 16'h0000
   };

endpackage

// [rcma_ref_src.sv]
/* model of the crystal and the two reference sources.
   assumes run and slow change just after the clock edge. */
`timescale 1ns/1ps
module rcma_ref_src (
   input wire logic clk,
   input wire logic [2:0] run,
   input wire logic [2:0] slow,
   output logic [2:0] lvl
);
   logic [2:0] div = 3'h0;
   logic [2:0] lvl_q = 3'h0;
   assign lvl = lvl_q;
   // running source toggles each cycle, each eighth when slow; stopped one holds
   always @(posedge clk) begin
      div <= div + 3'h1;
      lvl_q <= #1 lvl_q ^ (run & (~slow | {3{div == 3'h0}}));
   end
endmodule

// [ref_clock_monitor_alarms_test.sv]
/* self-checking bench for the reference clock monitor core.
   assumes the bound checker and the source model beside it. */
`timescale 1ns/1ps
module ref_clock_monitor_alarms_test
   import rcma_pkg::*;
;
   logic clk;
   logic resetn;
   logic ce;
   logic pd_ref_edge;
   logic [5:0] st_hold;
   int n_pd;
   logic cfg_write;
   logic clk_sel_pin;
   logic vco_tick;
   logic cfg_refused;
   logic out0_clk;
   logic out1_clk;
   logic [2:0] run;
   logic [2:0] slow;
   logic [2:0] lvl;
   rcma_cfg_t cfg_in;
   rcma_cfg_t cfg;
   rcma_cfg_t exp_cfg;
   rcma_cfg_t rnd;
   rcma_status_t status;
   integer seed;
   int n_errors;
   int samples_checked;
   logic [7:0] corn [5];

   rcma_ref_src u_src (.clk(clk), .run(run), .slow(slow), .lvl(lvl));
   rcma_core u_dut (.clk(clk), .resetn(resetn), .ce(ce), .cfg_write(cfg_write),
      .cfg_in(cfg_in), .clk_sel_pin(clk_sel_pin), .crystal_in(lvl[0]),
      .ref_input_zero(lvl[1]), .ref_input_one(lvl[2]), .vco_tick(vco_tick), .cfg(cfg),
      .cfg_refused(cfg_refused), .out0_clk(out0_clk), .out1_clk(out1_clk),
      .upper_fb_edge(), .lower_fb_edge(), .pd_ref_edge(pd_ref_edge), .crystal_fault_alarm(),
      .input_zero_fault_alarm(), .input_one_fault_alarm(), .pll_locked_flag(),
      .active_input(), .ref_lost_alarm(), .status(status));

   // clock and random oscillator ticks
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk) vco_tick <= #1 1'($random(seed));

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic chk(input logic [71:0] seen, input logic [71:0] want);
      samples_checked++;
      if (seen !== want) begin
         n_errors++;
         $display("mismatch t=%0t seen=%h want=%h", $time, seen, want);
      end
   endtask

   task automatic complete_run;
      if (n_errors == 0 && samples_checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   function automatic logic cfg_ok(input rcma_cfg_t c);
      return c.out0_divide_ratio inside {[8'h02:8'hfe]} && c.out1_divide_ratio inside
         {[8'h02:8'hfe]} && c.mode != 2'h3 && c.lower_loop_feedback_divider != 17'h0
         && c.upper_int_divider != 8'h0 && !(c.mode == RCMA_MODE_HIGH_BW && c.pre_divider < 8'h02);
   endfunction

   function automatic rcma_cfg_t mk(input rcma_mode_t m, input rcma_policy_t p,
      input logic [1:0] byp);
      rcma_cfg_t c;
      c = RCMA_CFG_DEFAULT;
      c.mode = m;
      c.switch_policy_field = p;
      c.output_ref_passthrough = byp;
      return c;
   endfunction

   task automatic wr(input rcma_cfg_t c);
      cfg_in = c;
      cfg_write = 1'b1;
      tick(1);
      cfg_write = 1'b0;
      if (cfg_ok(c)) exp_cfg = c;
      chk(cfg, exp_cfg);
      chk(cfg_refused, !cfg_ok(c));
      tick(1);
   endtask

   // bounded wait on one status bit, a timeout ends the run
   task automatic wait_st(input int b, input logic v, input int lim);
      int k;
      k = 0;
      while (status[b] !== v && k < lim) begin
         tick(1);
         k++;
      end
      chk(status[b], v);
      if (status[b] !== v) complete_run();
   endtask

   // reset, random words, then watchdog, switching and passthrough cases
   initial begin
      seed = 76234;
      n_errors = 0;
      samples_checked = 0;
      corn = '{8'h00, 8'h01, 8'h02, 8'hfe, 8'hff};
      {resetn, cfg_write, clk_sel_pin} = 3'h0;
      ce = 1'b1;
      cfg_in = RCMA_CFG_DEFAULT;
      exp_cfg = RCMA_CFG_DEFAULT;
      run = 3'h7;
      slow = 3'h0;
      tick(3);
      resetn = 1'b1;
      chk(cfg, RCMA_CFG_DEFAULT);
      chk(status, 6'h00);
      for (int i = 0; i < 40; i++) begin
         rnd = 72'({$random(seed), $random(seed), $random(seed)});
         if (i < 10) rnd.out0_divide_ratio = corn[i % 5];
         else if (i < 20) rnd.out1_divide_ratio = corn[i % 5];
         slow = 3'($random(seed));
         clk_sel_pin = 1'($random(seed));
         wr(rnd);
      end
      {slow, clk_sel_pin} = 4'h0;
      wr(mk(RCMA_MODE_LOW_BW, RCMA_POL_MANUAL_PIN, 2'h0));
      wait_st(2, 1'b1, 900);
      run = 3'h6;
      wait_st(5, 1'b1, 400);
      wait_st(2, 1'b0, 4);
      run = 3'h7;
      wait_st(5, 1'b0, 8);
      run = 3'h5;
      wait_st(4, 1'b1, 400);
      wait_st(0, 1'b1, 4);
      clk_sel_pin = 1'b1;
      wait_st(1, 1'b1, 4);
      wait_st(0, 1'b0, 4);
      run = 3'h7;
      wait_st(4, 1'b0, 8);
      wr(mk(RCMA_MODE_HIGH_BW, RCMA_POL_REVERTIVE, 2'h0));
      wait_st(2, 1'b1, 400);
      run = 3'h5;
      wait_st(1, 1'b1, 400);
      run = 3'h7;
      wait_st(1, 1'b0, 8);
      wr(mk(RCMA_MODE_HIGH_BW, RCMA_POL_NONREVERTIVE, 2'h0));
      run = 3'h5;
      wait_st(1, 1'b1, 400);
      run = 3'h7;
      // pre-divided reference pulses over a fixed window, active input held
      n_pd = 0;
      repeat (40) begin
         tick(1);
         n_pd += pd_ref_edge;
      end
      chk(status.active_input, 1'b1);
      chk(n_pd, 40 / (2 * RCMA_CFG_DEFAULT.pre_divider));
      run = 3'h3;
      wait_st(3, 1'b1, 400);
      wait_st(0, 1'b0, 4);
      run = 3'h1;
      wait_st(4, 1'b1, 400);
      wait_st(0, 1'b1, 4);
      run = 3'h7;
      wait_st(0, 1'b0, 8);
      clk_sel_pin = 1'b0;
      wr(mk(RCMA_MODE_HIGH_BW, RCMA_POL_MANUAL_PIN, 2'h3));
      run = 3'h5;
      tick(4);
      chk(out0_clk, lvl[1]);
      chk(out1_clk, lvl[1]);
      clk_sel_pin = 1'b1;
      run = 3'h3;
      tick(4);
      chk(out0_clk, lvl[2]);
      run = 3'h7;
      // register-driven manual select overrides the pin
      wr(mk(RCMA_MODE_HIGH_BW, RCMA_POL_MANUAL_REG, 2'h0));
      wait_st(1, 1'b0, 4);
      // clock enable low: no write lands, no alarm moves
      ce = 1'b0;
      st_hold = status;
      run = 3'h6;
      cfg_in = RCMA_CFG_DEFAULT;
      cfg_write = 1'b1;
      tick(1);
      cfg_write = 1'b0;
      tick(40);
      chk(cfg, exp_cfg);
      chk(status, st_hold);
      {ce, run} = 4'hf;
      // reset in mid-run brings back the defaults
      resetn = 1'b0;
      tick(2);
      resetn = 1'b1;
      exp_cfg = RCMA_CFG_DEFAULT;
      chk(cfg, exp_cfg);
      chk(status, 6'h00);
      rnd = mk(RCMA_MODE_SYNTH, RCMA_POL_MANUAL_PIN, 2'h0);
      rnd.upper_frac = 16'h8000;
      wr(rnd);
      wait_st(2, 1'b1, 400);
      complete_run();
   end
endmodule
